// ### common/osc_ctrl_pkg.sv
// Constants and types for the oscillator pin mode and run control block.
// Assumes a 100 MHz hclk and an AHB-Lite bus with 32-bit data.
package osc_ctrl_pkg;
    // Register byte offsets
    localparam logic [3:0] PIN_MODE_OFS = 4'h0;
    localparam logic [3:0] RUN_CTL_OFS  = 4'h4;
    localparam logic [3:0] CLK_SEL_OFS  = 4'h8;
    localparam int         ADDR_W       = 4;

    // Pin mode register fields
    localparam int MAIN_EXT_BIT   = 7;
    localparam int MAIN_PIN_BIT   = 6;
    localparam int SUB_EXT_BIT    = 5;
    localparam int SUB_PIN_BIT    = 4;
    localparam int DRIVE_HI_BIT   = 2;
    localparam int DRIVE_LO_BIT   = 1;
    localparam int FREQ_RANGE_BIT = 0;
    localparam logic [1:0] DRIVE_BAD = 2'h3;

    // Run control register fields
    localparam int MAIN_STOP_BIT = 7;
    localparam int SUB_STOP_BIT  = 6;
    localparam int IFO_STOP_BIT  = 0;
    localparam logic [7:0] RUN_CTL_MASK = 8'hc1;

    // System clock select register fields
    localparam int CPU_STS_BIT  = 7;
    localparam int CPU_SEL_BIT  = 6;
    localparam int MAIN_STS_BIT = 5;
    localparam int MAIN_SEL_BIT = 4;

    // Reset values
    localparam logic [7:0] PIN_MODE_RST = 8'h00;
    localparam logic [7:0] RUN_CTL_RST  = 8'hc0;

    // Synchroniser inputs: bit 0 main clock ready, bit 1 sub clock ready
    localparam int SYNC_W = 2;

    // Power state of the processor clock
    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_HALT = 2'b01,
        PWR_STOP = 2'b10
    } pwr_e;

    // Clock enables handed to the oscillator pads and clock tree
    typedef struct packed {
        logic       main_osc_en;
        logic       main_ext_en;
        logic       sub_osc_en;
        logic       sub_ext_en;
        logic [1:0] sub_drive;
        logic       main_freq_hi;
        logic       ifo_en;
        logic       cpu_src_sub;
        logic       main_src_hs;
        logic       cpu_clk_run;
    } clk_ctl_s;

    // Whole state of the control block
    typedef struct packed {
        logic [7:0]        pin_mode;
        logic [7:0]        run_ctl;
        logic              cpu_sel;
        logic              cpu_sts;
        logic              main_sel;
        logic              main_sts;
        pwr_e              pwr;
        logic              wr_pend;
        logic              rd_pend;
        logic [ADDR_W-1:0] addr;
        logic              ready;
        logic [31:0]       rdata;
        clk_ctl_s          ctl;
    } osc_st_s;
endpackage : osc_ctrl_pkg

// ### design/in_sync3.sv
// Three-stage synchroniser for levels arriving from outside hclk.
// Assumes inputs change slowly compared with hclk.
`timescale 1ns/1ps
module in_sync3 #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_st_s;

    sync_st_s st_r;
    sync_st_s st_nxt;
    logic [W-1:0] q_nxt;

    // A change counts only once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign q_nxt[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s3[i] : st_r.q[i];
    end

    // Next state of the chain
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q  = q_nxt;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule : in_sync3

// ### design/osc_ctrl.sv
// Oscillator pin mode, oscillator run control and processor clock source
// selection, reached over AHB-Lite. Assumes oscillator ready levels come
// from the analogue pads and standby requests from the core on hclk.
//
// Contract
// - Pin mode bits 7:6: 01 resonator, 11 external clock, else input ports.
// - Pin mode bits 5:4: 01 crystal, 11 external clock, else input ports.
// - Bits 2:1 drive mode 00 low power, 01 normal, 10 ultra low; 11 banned.
// - Bit 0 picks main frequency range: 0 is 1-10 MHz, 1 above 10 MHz.
// - Run control stop bits 7, 6, 0; bits 5:1 read as zero.
// - Halt or stop standby stops the processor clock until a wake event.
// - Stop bit 7 lets the main oscillator or external clock run; 1 stops it.
// - Select bit 6 picks main or sub clock; status bit 7 shows the source.
// - Select bit 4 picks internal or high speed main; status bit 5 shows it.
`timescale 1ns/1ps
module osc_ctrl (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Oscillator ready levels from the pads
    input  wire logic        main_clk_ready,
    input  wire logic        sub_clk_ready,
    // Standby requests and wake from the core
    input  wire logic        halt_req,
    input  wire logic        stop_req,
    input  wire logic        wake_evt,
    // Clock controls
    output osc_ctrl_pkg::clk_ctl_s clk_ctl
);
    osc_ctrl_pkg::osc_st_s st_r;
    osc_ctrl_pkg::osc_st_s st_nxt;
    logic [osc_ctrl_pkg::SYNC_W-1:0] ready_sync;
    logic                            main_rdy;
    logic                            sub_rdy;
    logic                            ifo_rdy;
    logic                            accept;

    // Ready levels are asynchronous to hclk
    in_sync3 #(
        .W (osc_ctrl_pkg::SYNC_W)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({sub_clk_ready, main_clk_ready}),
        .q       (ready_sync)
    );

    assign main_rdy = ready_sync[0];
    assign sub_rdy  = ready_sync[1];
    // Internal oscillator is taken as usable as soon as it runs
    assign ifo_rdy  = !st_r.run_ctl[osc_ctrl_pkg::IFO_STOP_BIT];
    assign accept   = hsel && hready && htrans[1];

    // Register decode, clock switching and standby control
    always_comb begin
        logic [7:0] wb;
        logic [1:0] drv;
        logic [1:0] mpin;
        logic [1:0] spin;
        logic       frozen;
        wb     = hwdata[7:0];
        drv    = 2'h0;
        mpin   = 2'h0;
        spin   = 2'h0;
        frozen = 1'b0;
        st_nxt = st_r;

        // Reads take one wait state so a preceding write is always seen
        st_nxt.ready = 1'b1;
        st_nxt.rd_pend = 1'b0;
        st_nxt.wr_pend = 1'b0;
        if (st_r.rd_pend) begin
            st_nxt.rdata = 32'h0000_0000;
            case (st_r.addr)
                osc_ctrl_pkg::PIN_MODE_OFS: st_nxt.rdata[7:0] = st_r.pin_mode;
                osc_ctrl_pkg::RUN_CTL_OFS: begin
                    st_nxt.rdata[7:0] = st_r.run_ctl & osc_ctrl_pkg::RUN_CTL_MASK;
                end
                osc_ctrl_pkg::CLK_SEL_OFS: begin
                    st_nxt.rdata[osc_ctrl_pkg::CPU_STS_BIT]  = st_r.cpu_sts;
                    st_nxt.rdata[osc_ctrl_pkg::CPU_SEL_BIT]  = st_r.cpu_sel;
                    st_nxt.rdata[osc_ctrl_pkg::MAIN_STS_BIT] = st_r.main_sts;
                    st_nxt.rdata[osc_ctrl_pkg::MAIN_SEL_BIT] = st_r.main_sel;
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Data phase of a write
        if (st_r.wr_pend) begin
            case (st_r.addr)
                osc_ctrl_pkg::PIN_MODE_OFS: begin
                    st_nxt.pin_mode = wb & 8'hf7;
                    // The banned drive code is refused; the old drive bits stay
                    if (wb[osc_ctrl_pkg::DRIVE_HI_BIT -: 2] == osc_ctrl_pkg::DRIVE_BAD) begin
                        st_nxt.pin_mode[osc_ctrl_pkg::DRIVE_HI_BIT -: 2] =
                            st_r.pin_mode[osc_ctrl_pkg::DRIVE_HI_BIT -: 2];
                    end
                end
                osc_ctrl_pkg::RUN_CTL_OFS: begin
                    st_nxt.run_ctl = wb & osc_ctrl_pkg::RUN_CTL_MASK;
                end
                osc_ctrl_pkg::CLK_SEL_OFS: begin
                    st_nxt.cpu_sel  = wb[osc_ctrl_pkg::CPU_SEL_BIT];
                    st_nxt.main_sel = wb[osc_ctrl_pkg::MAIN_SEL_BIT];
                end
                default: st_nxt.pin_mode = st_r.pin_mode;
            endcase
        end

        // Address phase
        if (accept) begin
            st_nxt.addr    = haddr[osc_ctrl_pkg::ADDR_W-1:0];
            st_nxt.wr_pend = hwrite;
            st_nxt.rd_pend = !hwrite;
            st_nxt.ready   = hwrite;
        end

        // Status follows a selection only once the target clock is ready
        if (st_r.main_sel && main_rdy) begin
            st_nxt.main_sts = 1'b1;
        end else if (!st_r.main_sel && ifo_rdy) begin
            st_nxt.main_sts = 1'b0;
        end
        if (st_r.cpu_sel && sub_rdy) begin
            st_nxt.cpu_sts = 1'b1;
        end else if (!st_r.cpu_sel && (st_r.main_sts ? main_rdy : ifo_rdy)) begin
            st_nxt.cpu_sts = 1'b0;
        end

        // Standby: in run a request wins over wake in the same cycle; halt and stop leave only on wake
        case (st_r.pwr)
            osc_ctrl_pkg::PWR_RUN: begin
                if (stop_req) begin
                    st_nxt.pwr = osc_ctrl_pkg::PWR_STOP;
                end else if (halt_req) begin
                    st_nxt.pwr = osc_ctrl_pkg::PWR_HALT;
                end
            end
            osc_ctrl_pkg::PWR_HALT,
            osc_ctrl_pkg::PWR_STOP: begin
                if (wake_evt) begin
                    st_nxt.pwr = osc_ctrl_pkg::PWR_RUN;
                end
            end
            default: st_nxt.pwr = osc_ctrl_pkg::PWR_RUN;
        endcase

        // Pad controls; stop standby also halts every oscillator
        drv    = st_r.pin_mode[osc_ctrl_pkg::DRIVE_HI_BIT -: 2];
        mpin   = st_r.pin_mode[osc_ctrl_pkg::MAIN_EXT_BIT -: 2];
        spin   = st_r.pin_mode[osc_ctrl_pkg::SUB_EXT_BIT -: 2];
        frozen = (st_r.pwr == osc_ctrl_pkg::PWR_STOP);
        st_nxt.ctl.main_osc_en = (mpin == 2'h1) && !frozen &&
                                 !st_r.run_ctl[osc_ctrl_pkg::MAIN_STOP_BIT];
        st_nxt.ctl.main_ext_en = (mpin == 2'h3) && !frozen &&
                                 !st_r.run_ctl[osc_ctrl_pkg::MAIN_STOP_BIT];
        st_nxt.ctl.sub_osc_en  = (spin == 2'h1) && !frozen &&
                                 !st_r.run_ctl[osc_ctrl_pkg::SUB_STOP_BIT];
        st_nxt.ctl.sub_ext_en  = (spin == 2'h3) && !frozen &&
                                 !st_r.run_ctl[osc_ctrl_pkg::SUB_STOP_BIT];
        st_nxt.ctl.sub_drive   = drv;
        st_nxt.ctl.main_freq_hi = st_r.pin_mode[osc_ctrl_pkg::FREQ_RANGE_BIT];
        st_nxt.ctl.ifo_en      = ifo_rdy && !frozen;
        st_nxt.ctl.cpu_src_sub = st_r.cpu_sts;
        st_nxt.ctl.main_src_hs = st_r.main_sts;
        st_nxt.ctl.cpu_clk_run = (st_nxt.pwr == osc_ctrl_pkg::PWR_RUN);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r          <= '0;
            st_r.pin_mode <= osc_ctrl_pkg::PIN_MODE_RST;
            st_r.run_ctl  <= osc_ctrl_pkg::RUN_CTL_RST;
            st_r.pwr      <= osc_ctrl_pkg::PWR_RUN;
            st_r.ready    <= 1'b1;
            st_r.ctl.cpu_clk_run <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register; response is always OKAY
    assign hrdata    = st_r.rdata;
    assign hreadyout = st_r.ready;
    assign hresp     = 1'b0;
    assign clk_ctl   = st_r.ctl;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    main_pin_mode_a: assert property (
        st_r.pin_mode[7:6] != 2'h1 |=> !clk_ctl.main_osc_en)
        else $error("main oscillator enabled outside resonator mode");
    sub_ext_mode_a: assert property (
        clk_ctl.sub_ext_en |-> $past(st_r.pin_mode[5:4]) == 2'h3)
        else $error("sub external clock enabled outside external mode");
    drive_code_a: assert property (
        clk_ctl.sub_drive != 2'h3)
        else $error("banned drive code reached the pad");
    freq_range_a: assert property (
        st_r.wr_pend && st_r.addr == 4'h0 |=> ##1 clk_ctl.main_freq_hi == $past(hwdata[0], 2))
        else $error("frequency range did not follow the write");
    run_ctl_zero_a: assert property (
        (st_r.run_ctl & 8'h3e) == 8'h00)
        else $error("reserved run control bits set");
    standby_gate_a: assert property (
        (st_r.pwr == osc_ctrl_pkg::PWR_RUN && (halt_req || stop_req)) ||
        (st_r.pwr != osc_ctrl_pkg::PWR_RUN && !wake_evt) |=> !clk_ctl.cpu_clk_run)
        else $error("processor clock ran during standby");
    standby_bound_a: assert property (
        st_r.pwr != osc_ctrl_pkg::PWR_RUN && wake_evt |=> clk_ctl.cpu_clk_run)
        else $error("processor clock did not restart on wake");
    stop_bit_a: assert property (
        st_r.run_ctl[6] |=> !clk_ctl.sub_osc_en && !clk_ctl.sub_ext_en)
        else $error("sub oscillator ran while stopped");
    cpu_status_a: assert property (
        $rose(st_r.cpu_sts) |-> $past(st_r.cpu_sel) && $past(sub_rdy))
        else $error("cpu status moved to sub clock before it was ready");
    main_status_a: assert property (
        st_r.main_sel && main_rdy |=> st_r.main_sts ##1 clk_ctl.main_src_hs)
        else $error("main status did not follow selection");
    read_wait_a: assert property (
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");
endmodule : osc_ctrl

// ### test/osc_model.sv
// Behavioural crystals and clock sources on the oscillator pins.
// Assumes the clock enables of the control block; ready levels go back to it.
`timescale 1ns/1ps
module osc_model (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // Start-up speed, 1 for a slow crystal
    input  wire logic                   slow,
    // Enables from the control block
    input  wire osc_ctrl_pkg::clk_ctl_s clk_ctl,
    // Ready levels to the control block
    output logic                        main_clk_ready,
    output logic                        sub_clk_ready
);
    logic [7:0] main_cnt;
    logic [7:0] sub_cnt;
    logic [7:0] lim;
    logic       main_on;
    logic       sub_on;
    // A source runs only in resonator or external mode with its stop bit clear
    assign main_on = clk_ctl.main_osc_en | clk_ctl.main_ext_en;
    assign sub_on  = clk_ctl.sub_osc_en | clk_ctl.sub_ext_en;
    assign lim     = slow ? 8'h28 : 8'h04;
    // Start-up count; a stopped source loses ready at once, never lingers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_cnt <= 8'h00;
            sub_cnt  <= 8'h00;
        end else begin
            main_cnt <= !main_on ? 8'h00 : (main_cnt >= lim ? main_cnt : main_cnt + 8'h01);
            sub_cnt  <= !sub_on ? 8'h00 : (sub_cnt >= lim ? sub_cnt : sub_cnt + 8'h01);
        end
    end
    assign main_clk_ready = main_on && main_cnt >= lim;
    assign sub_clk_ready  = sub_on && sub_cnt >= lim;
endmodule : osc_model

// ### test/osc_ctrl_bench.sv
// Self-checking bench for the oscillator control block.
// Assumes a single AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module osc_ctrl_bench;
    logic                   hclk = 1'b0;
    logic                   hresetn = 1'b0;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = 32'h0;
    logic [1:0]             htrans = 2'h0;
    logic                   hwrite = 1'b0;
    logic [2:0]             hsize = 3'h2;
    logic [31:0]            hwdata = 32'h0;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    logic                   main_clk_ready;
    logic                   sub_clk_ready;
    logic                   halt_req = 1'b0;
    logic                   stop_req = 1'b0;
    logic                   wake_evt = 1'b0;
    logic                   slow = 1'b0;
    osc_ctrl_pkg::clk_ctl_s clk_ctl;
    logic [31:0]            exp_q[$];
    logic                   rd_ph = 1'b0;
    logic [15:0]            rnd = 16'h3687;
    int                     failures = 0;
    int                     total_checks = 0;

    osc_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .main_clk_ready(main_clk_ready), .sub_clk_ready(sub_clk_ready),
        .halt_req(halt_req), .stop_req(stop_req), .wake_evt(wake_evt), .clk_ctl(clk_ctl));
    osc_model partner (.hclk(hclk), .hresetn(hresetn), .slow(slow), .clk_ctl(clk_ctl),
        .main_clk_ready(main_clk_ready), .sub_clk_ready(sub_clk_ready));

    // 100 MHz clock
    always #5 hclk = ~hclk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // Read data leave the queue in bus order, at the edge that ends the data phase
    always @(posedge hclk) begin
        if (hresp !== 1'b0) chk({31'h0, hresp}, 32'h0);
        if (rd_ph && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
        if (hreadyout === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
    end

    // One single transfer; address held until hready, then data phase
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {28'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : wt

    // Pulse of {stop_req, halt_req, wake_evt}, sampled by one edge
    task automatic pulse(input logic [2:0] k);
        @(posedge hclk);
        {stop_req, halt_req, wake_evt} <= k;
        @(posedge hclk);
        {stop_req, halt_req, wake_evt} <= 3'h0;
        #1;
    endtask : pulse

    // Enables, drive, range, internal oscillator and processor clock run
    task automatic en(input logic [8:0] e);
        chk({23'h0, clk_ctl.main_osc_en, clk_ctl.main_ext_en, clk_ctl.sub_osc_en,
            clk_ctl.sub_ext_en, clk_ctl.sub_drive, clk_ctl.main_freq_hi,
            clk_ctl.ifo_en, clk_ctl.cpu_clk_run}, {23'h0, e});
    endtask : en

    // Source switches wait on oscillator start-up, so poll with a bound
    task automatic waitc(input logic [1:0] e);
        int n;
        n = 0;
        while ({clk_ctl.cpu_src_sub, clk_ctl.main_src_hs} !== e && n < 300) begin
            @(posedge hclk);
            n++;
        end
        #1;
        chk({30'h0, clk_ctl.cpu_src_sub, clk_ctl.main_src_hs}, {30'h0, e});
    endtask : waitc

    // Guard against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        final_report();
    end

    initial begin
        logic [7:0] p;
        logic [1:0] dv;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'hc0);
        rd(4'h8, 8'h00);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        wt(2);
        en(9'h003);
        wr(4'h4, 8'h00);
        // Every pin mode pair, random drive, range and reserved bit
        for (int v = 0; v < 16; v++) begin
            rnd = lfsr(rnd);
            dv = (rnd[1:0] == 2'h3) ? 2'h2 : rnd[1:0];
            p = {v[3:0], rnd[3], dv, rnd[2]};
            wr(4'h0, p);
            rd(4'h0, p & 8'hf7);
            wt(2);
            en({v[3:2] == 2'h1, v[3:2] == 2'h3, v[1:0] == 2'h1, v[1:0] == 2'h3,
                dv, rnd[2], 2'h3});
        end
        wr(4'h0, 8'h53);
        wr(4'h0, 8'h17);
        rd(4'h0, 8'h13);
        wr(4'h4, 8'hff);
        rd(4'h4, 8'hc1);
        wt(2);
        en(9'h00d);
        wr(4'h0, 8'h53);
        // Resonator mode on both pins, but both stop bits still set
        wt(2);
        en(9'h00d);
        slow <= 1'b1;
        wr(4'h4, 8'h00);
        wt(2);
        en(9'h14f);
        wr(4'h8, 8'h10);
        rd(4'h8, 8'h10);
        waitc(2'h1);
        rd(4'h8, 8'h30);
        wr(4'h8, 8'h50);
        waitc(2'h3);
        rd(4'h8, 8'hf0);
        pulse(3'h2);
        en(9'h14e);
        wt(4);
        en(9'h14e);
        pulse(3'h1);
        en(9'h14f);
        pulse(3'h6);
        wt(2);
        en(9'h00c);
        // A halt request while stopped is ignored; stop stays in force
        pulse(3'h2);
        en(9'h00c);
        pulse(3'h1);
        wt(2);
        en(9'h14f);
        wr(4'h8, 8'h10);
        waitc(2'h1);
        rd(4'h8, 8'h30);
        wr(4'h8, 8'h00);
        waitc(2'h0);
        rd(4'h8, 8'h00);
        wt(2);
        final_report();
    end
endmodule : osc_ctrl_bench
